// >>> inc/psrs_params.svh
// Constants for the power-save and reset-status block
// Overview of operation
// [RULE1] Every kind of device reset sets its own cause flag in the reset-cause register.
// [RULE2] Power-on reset clears the register except brown-out and power-on flags, which set.
// [RULE3] Software may set or clear any cause bit; doing so never resets the device.
// [RULE4] Bit 3 sleep-wake, bit 2 idle-wake, bit 1 brown-out, bit 0 power-on flag.
// [RULE5] Software should clear cause bits after reading them.
// [RULE6] Watchdog fuse at 1 keeps watchdog enabled regardless of software enable.
// [RULE7] Entering idle stops instruction execution and clears the watchdog timer.
// [RULE8] In idle, clocks and peripherals keep running; low-power oscillator stays if needed.
// [RULE9] Idle ends on enabled interrupt, any device reset, or watchdog time-out.
// [RULE10] After idle wake, CPU clock returns and execution resumes 2-4 cycles later.
// [RULE11] Interrupt coinciding with power-save instruction waits until entry completes.
// [RULE12] Doze slows only the CPU clock; peripherals run full rate, domains aligned.
// [RULE13] Bit 11 of the clock divider register enables doze.
// [RULE14] Bits 14:12 pick ratio among eight settings 1:1 to 1:128, default 1:1.
// [RULE15] Bit 15 set lets an interrupt end doze; clear leaves doze unchanged.
// [RULE16] Module-disable bit stops the peripheral's clocks and its register access.
// [RULE17] Peripheral enabled only if present and its disable bit clear; resets enabled.
// [RULE18] Disable bit change reaches the peripheral after one instruction cycle.
// [RULE19] Ratio field n gives CPU clock equal to peripheral clock over two to the n.
// [RULE20] Non-power-on resets set only their own flag, keeping other bits.
`ifndef PSRS_PARAMS_SVH
`define PSRS_PARAMS_SVH
`define PSRS_ADDR_W 12
`define PSRS_OFF_RCAUSE 12'h000
`define PSRS_OFF_CLOCK_DIVIDER_REGISTER 12'h004
`define PSRS_OFF_MODDIS 12'h008
`define PSRS_OFF_STATE 12'h00c
`define PSRS_RCAUSE_POR_VAL 16'h0003
`define PSRS_RCAUSE_MASK 16'h00ff
`define PSRS_BIT_POR 0
`define PSRS_BIT_BOR 1
`define PSRS_BIT_IDLE 2
`define PSRS_BIT_SLEEP 3
`define PSRS_BIT_WDTO 4
`define PSRS_BIT_WATCHDOG_SOFT_ENABLE 5
`define PSRS_BIT_SWR 6
`define PSRS_BIT_EXTR 7
`define PSRS_CLOCK_DIVIDER_REGISTER_MASK 16'hf800
`define PSRS_CLOCK_DIVIDER_REGISTER_RST 16'h0000
`define PSRS_BIT_ROI 15
`define PSRS_DOZE_HI 14
`define PSRS_DOZE_LO 12
`define PSRS_BIT_CPU_SLOW_ENABLE 11
`define PSRS_NPERIPH 16
`define PSRS_PRESENT 16'h7fff
`define PSRS_MODDIS_RST 16'h0000
`define PSRS_WAKE_CYC 2'h3
`endif

// >>> inc/psrs_pkg.sv
// Types shared by the power-save and reset-status block
package psrs_pkg;
  typedef enum logic [1:0] {PSRS_RUN, PSRS_ENTER, PSRS_IDLE, PSRS_WAKE} psrs_state_t;
  typedef logic [2:0] psrs_ratio_t;
endpackage

// >>> hw/psrs_doze_tick.sv
// CPU clock-enable tick generator for doze mode
`timescale 1ns/1ps
`include "psrs_params.svh"
module psrs_doze_tick (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic doze_en,
  input wire psrs_pkg::psrs_ratio_t ratio,
  // Tick out
  output logic tick
);
  import psrs_pkg::*;
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] mask;
  logic tick_reg;
  logic tick_next;

  // Free counter keeps both domains phase-locked to pclk [RULE12]
  always_comb begin
    mask = 7'h7f >> (3'h7 - ratio);
    cnt_next = cnt_reg + 7'h01;
    tick_next = !doze_en || ((cnt_next & mask) == 7'h00); // [RULE19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  a_ratio_one: assert property (@(posedge pclk) disable iff (!presetn)
    (!doze_en) |=> tick) // [RULE19]
    else $error("Tick missing with doze off");
endmodule

// >>> hw/psrs_top.sv
// Power-save sequencer, doze control, module disable and reset-cause status
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "psrs_params.svh"
module psrs_top (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reset and sleep-wake events, one-cycle pulses
  input wire logic brownout_evt,
  input wire logic wdt_reset_evt,
  input wire logic sw_reset_evt,
  input wire logic ext_reset_evt,
  input wire logic sleep_wake_evt,
  // CPU side
  input wire logic power_save_instr,
  input wire logic irq_pending,
  output logic cpu_clk_en,
  output logic cpu_run,
  // Watchdog and oscillator
  input wire logic watchdog_fuse_enable,
  input wire logic wdt_timeout,
  input wire logic fail_safe_clock_monitor,
  output logic watchdog_enable,
  output logic watchdog_clear,
  output logic low_power_rc_osc_en,
  // Peripheral enables
  output logic [15:0] periph_en
);
  import psrs_pkg::*;

  psrs_state_t state_reg;
  psrs_state_t state_next;
  logic [1:0] wake_cnt_reg;
  logic [1:0] wake_cnt_next;
  logic cpu_run_reg;
  logic cpu_run_next;
  logic cpu_clk_reg;
  logic cpu_clk_next;
  logic wdt_clr_reg;
  logic wdt_clr_next;
  logic [15:0] rcause_reg;
  logic [15:0] rcause_next;
  logic [15:0] clock_divider_register_reg;
  logic [15:0] clock_divider_register_next;
  logic [15:0] moddis_reg;
  logic [15:0] moddis_next;
  logic [15:0] pen_reg;
  logic [15:0] pen_next;
  logic wdt_en_reg;
  logic wdt_en_next;
  logic low_power_rc_osc_reg;
  logic low_power_rc_osc_next;
  logic fuse_s1_reg;
  logic fuse_s2_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic doze_tick;
  logic any_reset;
  logic wake_src;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_val;
  logic first_reg;

  // Fuse is a strap from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_s1_reg <= 1'b1;
      fuse_s2_reg <= 1'b1;
    end else begin
      fuse_s1_reg <= watchdog_fuse_enable;
      fuse_s2_reg <= fuse_s1_reg;
    end
  end

  psrs_doze_tick u_doze (
    .pclk(pclk),
    .presetn(presetn),
    .doze_en(clock_divider_register_reg[`PSRS_BIT_CPU_SLOW_ENABLE]), // [RULE13]
    .ratio(clock_divider_register_reg[`PSRS_DOZE_HI:`PSRS_DOZE_LO]), // [RULE14]
    .tick(doze_tick)
  );

  // APB decode; one wait state keeps all outputs registered
  always_comb begin
    mapped = (paddr == `PSRS_OFF_RCAUSE) || (paddr == `PSRS_OFF_CLOCK_DIVIDER_REGISTER) ||
             (paddr == `PSRS_OFF_MODDIS) || (paddr == `PSRS_OFF_STATE);
    wr_done = psel && penable && pready_reg && pwrite && mapped;
    rd_val = 32'h0000_0000;
    unique case (paddr)
      `PSRS_OFF_RCAUSE: rd_val[15:0] = rcause_reg;
      `PSRS_OFF_CLOCK_DIVIDER_REGISTER: rd_val[15:0] = clock_divider_register_reg;
      `PSRS_OFF_MODDIS: rd_val[15:0] = moddis_reg;
      `PSRS_OFF_STATE: rd_val[15:0] = {12'h000, cpu_clk_reg, cpu_run_reg, state_reg};
      default: rd_val = 32'h0000_0000;
    endcase
    pready_next = psel && penable && !pready_reg;
    prdata_next = pready_next ? rd_val : 32'h0000_0000;
    pslverr_next = pready_next && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= pready_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Any reset seen by this block wakes it from idle
  assign any_reset = brownout_evt | wdt_reset_evt | sw_reset_evt | ext_reset_evt;
  assign wake_src = irq_pending | any_reset | wdt_timeout;

  // Reset-cause register: event sets win over a same-cycle software clear
  always_comb begin
    rcause_next = rcause_reg;
    if (wr_done && paddr == `PSRS_OFF_RCAUSE) begin
      rcause_next = pwdata[15:0] & `PSRS_RCAUSE_MASK; // [RULE3]
    end
    if (brownout_evt) begin
      rcause_next[`PSRS_BIT_BOR] = 1'b1; // [RULE1] [RULE20]
    end
    if (wdt_reset_evt) begin
      rcause_next[`PSRS_BIT_WDTO] = 1'b1; // [RULE1] [RULE20]
    end
    if (sw_reset_evt) begin
      rcause_next[`PSRS_BIT_SWR] = 1'b1; // [RULE1] [RULE20]
    end
    if (ext_reset_evt) begin
      rcause_next[`PSRS_BIT_EXTR] = 1'b1; // [RULE1] [RULE20]
    end
    if (sleep_wake_evt) begin
      rcause_next[`PSRS_BIT_SLEEP] = 1'b1; // [RULE4]
    end
    if (state_reg == PSRS_IDLE && wake_src) begin
      rcause_next[`PSRS_BIT_IDLE] = 1'b1; // [RULE4]
    end
  end

  // Power-on is the asynchronous reset of this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcause_reg <= `PSRS_RCAUSE_POR_VAL; // [RULE2]
      first_reg <= 1'b1;
    end else begin
      rcause_reg <= rcause_next;
      first_reg <= 1'b0;
    end
  end

  // Clock divider and module disable registers
  always_comb begin
    clock_divider_register_next = clock_divider_register_reg;
    moddis_next = moddis_reg;
    if (wr_done && paddr == `PSRS_OFF_CLOCK_DIVIDER_REGISTER) begin
      clock_divider_register_next = pwdata[15:0] & `PSRS_CLOCK_DIVIDER_REGISTER_MASK;
    end
    if (wr_done && paddr == `PSRS_OFF_MODDIS) begin
      moddis_next = pwdata[15:0];
    end
    // Hardware exit from doze beats a same-cycle write
    if (irq_pending && clock_divider_register_reg[`PSRS_BIT_ROI]) begin
      clock_divider_register_next[`PSRS_BIT_CPU_SLOW_ENABLE] = 1'b0; // [RULE15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_register_reg <= `PSRS_CLOCK_DIVIDER_REGISTER_RST; // [RULE14]
      moddis_reg <= `PSRS_MODDIS_RST; // [RULE17]
    end else begin
      clock_divider_register_reg <= clock_divider_register_next;
      moddis_reg <= moddis_next;
    end
  end

  // Per-peripheral gate, updated once per instruction cycle
  genvar gi;
  generate
    for (gi = 0; gi < `PSRS_NPERIPH; gi = gi + 1) begin : g_periph
      localparam logic [15:0] PRESENT = `PSRS_PRESENT;
      always_comb begin
        pen_next[gi] = doze_tick ? (PRESENT[gi] & ~moddis_reg[gi]) : pen_reg[gi]; // [RULE16] [RULE17] [RULE18]
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pen_reg <= `PSRS_PRESENT; // [RULE17]
    end else begin
      pen_reg <= pen_next;
    end
  end

  // Idle sequencer
  always_comb begin
    state_next = state_reg;
    wake_cnt_next = wake_cnt_reg;
    cpu_run_next = cpu_run_reg;
    wdt_clr_next = 1'b0;
    unique case (state_reg)
      PSRS_RUN: begin
        if (power_save_instr) begin
          state_next = PSRS_ENTER;
          cpu_run_next = 1'b0; // [RULE7]
          wdt_clr_next = 1'b1; // [RULE7]
        end
      end
      // Entry always completes; a coincident interrupt is looked at only in idle
      PSRS_ENTER: state_next = PSRS_IDLE; // [RULE11]
      PSRS_IDLE: begin
        if (wake_src) begin
          state_next = PSRS_WAKE; // [RULE9]
          wake_cnt_next = 2'h1;
        end
      end
      PSRS_WAKE: begin
        wake_cnt_next = wake_cnt_reg + 2'h1;
        if (wake_cnt_reg == `PSRS_WAKE_CYC) begin
          state_next = PSRS_RUN;
          cpu_run_next = 1'b1; // [RULE10]
        end
      end
    endcase
    // CPU clock is back from the first wake cycle, subject to doze
    cpu_clk_next = (state_next != PSRS_ENTER && state_next != PSRS_IDLE) && doze_tick; // [RULE10] [RULE12]
    wdt_en_next = fuse_s2_reg | rcause_reg[`PSRS_BIT_WATCHDOG_SOFT_ENABLE]; // [RULE6]
    low_power_rc_osc_next = wdt_en_next | fail_safe_clock_monitor; // [RULE8]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PSRS_RUN;
      wake_cnt_reg <= 2'h0;
      cpu_run_reg <= 1'b1;
      cpu_clk_reg <= 1'b1;
      wdt_clr_reg <= 1'b0;
      wdt_en_reg <= 1'b1;
      low_power_rc_osc_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      wake_cnt_reg <= wake_cnt_next;
      cpu_run_reg <= cpu_run_next;
      cpu_clk_reg <= cpu_clk_next;
      wdt_clr_reg <= wdt_clr_next;
      wdt_en_reg <= wdt_en_next;
      low_power_rc_osc_reg <= low_power_rc_osc_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_clk_en = cpu_clk_reg;
  assign cpu_run = cpu_run_reg;
  assign watchdog_enable = wdt_en_reg;
  assign watchdog_clear = wdt_clr_reg;
  assign low_power_rc_osc_en = low_power_rc_osc_reg;
  assign periph_en = pen_reg;

  a_bor_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    brownout_evt |=> rcause_reg[`PSRS_BIT_BOR])
    else $error("Brown-out flag not set");
  a_por_init_value: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    first_reg |-> rcause_reg == `PSRS_RCAUSE_POR_VAL)
    else $error("Power-on value wrong");
  a_fuse_forces_wdt: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    fuse_s2_reg |=> watchdog_enable)
    else $error("Watchdog not forced on by fuse");
  a_idle_entry_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    (state_reg == PSRS_RUN && power_save_instr) |=> (watchdog_clear && !cpu_run) ##1 !watchdog_clear)
    else $error("Idle entry did not clear watchdog");
  a_idle_wake_src: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    (state_reg == PSRS_IDLE && wake_src) |=> state_reg == PSRS_WAKE && rcause_reg[`PSRS_BIT_IDLE])
    else $error("Idle did not end on wake event");
  a_wake_latency: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    (state_reg == PSRS_IDLE && wake_src) |-> !cpu_run [*3] ##[1:2] cpu_run)
    else $error("Wake latency outside 2-4 cycles");
  a_entry_completes: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    state_reg == PSRS_ENTER |=> state_reg == PSRS_IDLE)
    else $error("Idle entry interrupted");
  a_roi_exit_doze: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    (irq_pending && clock_divider_register_reg[`PSRS_BIT_ROI]) |=> !clock_divider_register_reg[`PSRS_BIT_CPU_SLOW_ENABLE])
    else $error("Interrupt did not end doze");
  a_moddis_follows: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    $changed(pen_reg) |-> $past(doze_tick) && (pen_reg == (`PSRS_PRESENT & ~$past(moddis_reg))))
    else $error("Peripheral enable changed off an instruction cycle");
  a_absent_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    (pen_reg & ~`PSRS_PRESENT) == 16'h0000)
    else $error("Absent peripheral enabled");
endmodule

// >>> verification/psrs_cpu_model.sv
// CPU model issuing the power-save instruction and interrupt requests
`timescale 1ns/1ps
module psrs_cpu_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests and the block's run status
  input wire logic go,
  input wire logic irq_req,
  input wire logic cpu_run,
  // To the block
  output logic power_save_instr,
  output logic irq_pending
);
  // A halted core cannot issue another power-save instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_save_instr <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      power_save_instr <= go & cpu_run;
      irq_pending <= irq_req;
    end
  end
endmodule

// >>> verification/tb_power_save_reset_status.sv
// Self-checking bench for the power-save and reset-status block
`timescale 1ns/1ps
`include "psrs_params.svh"
module tb_power_save_reset_status;
  import psrs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] evt;
  logic power_save_instr, irq_pending, cpu_clk_en, cpu_run, go, irq_req;
  logic watchdog_fuse_enable, fail_safe_clock_monitor;
  logic watchdog_enable, watchdog_clear, low_power_rc_osc_en;
  logic [15:0] periph_en;
  int num_errors = 0;
  int check_count = 0;
  psrs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_evt(evt[0]), .wdt_reset_evt(evt[1]), .sw_reset_evt(evt[2]), .ext_reset_evt(evt[3]),
    .sleep_wake_evt(evt[4]), .power_save_instr(power_save_instr), .irq_pending(irq_pending),
    .cpu_clk_en(cpu_clk_en), .cpu_run(cpu_run), .watchdog_fuse_enable(watchdog_fuse_enable),
    .wdt_timeout(evt[5]), .fail_safe_clock_monitor(fail_safe_clock_monitor),
    .watchdog_enable(watchdog_enable), .watchdog_clear(watchdog_clear),
    .low_power_rc_osc_en(low_power_rc_osc_en), .periph_en(periph_en));
  psrs_cpu_model cpu (.pclk(pclk), .presetn(presetn), .go(go), .irq_req(irq_req), .cpu_run(cpu_run),
    .power_save_instr(power_save_instr), .irq_pending(irq_pending));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) chk("pready", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
    chk("slverr", {31'h0, err}, 32'h0);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic t_reset();
    rchk("cause", `PSRS_OFF_RCAUSE, 32'h3);
    rchk("clock_divider_register", `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h0);
    rchk("moddis", `PSRS_OFF_MODDIS, 32'h0);
    chk("periph_en", periph_en, 16'h7fff);
    rchk("state", `PSRS_OFF_STATE, 32'hc);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped rd", rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_cause();
    int pos [5] = '{1, 4, 6, 7, 3};
    apb(1'b1, `PSRS_OFF_RCAUSE, 32'h20);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      evt <= 6'h1 << i;
      @(posedge pclk);
      evt <= 6'h0;
      rchk("cause", `PSRS_OFF_RCAUSE, 32'h20 | (32'h1 << pos[i]));
      apb(1'b1, `PSRS_OFF_RCAUSE, 32'h20);
    end
    apb(1'b1, `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h3000);
    apb(1'b1, `PSRS_OFF_RCAUSE, 32'hffff);
    rchk("cause sw", `PSRS_OFF_RCAUSE, 32'hff);
    rchk("kept", `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h3000);
    apb(1'b1, `PSRS_OFF_RCAUSE, 32'h0);
    fail_safe_clock_monitor <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("wd en", {watchdog_enable, low_power_rc_osc_en}, 2'b01);
    watchdog_fuse_enable <= 1'b1;
    fail_safe_clock_monitor <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("wd fuse", {watchdog_enable, low_power_rc_osc_en}, 2'b11);
    watchdog_fuse_enable <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("osc off", low_power_rc_osc_en, 1'b0);
    $display("test cause done");
  endtask
  task automatic t_idle(input int src, input bit coinc);
    int n;
    apb(1'b1, `PSRS_OFF_RCAUSE, 32'h0);
    go <= 1'b1;
    irq_req <= coinc;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (watchdog_clear !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    chk("wd clear", n < 8, 1'b1);
    chk("halted", cpu_run, 1'b0);
    if (!coinc) begin
      repeat (4) @(posedge pclk);
      chk("idle", {cpu_run, cpu_clk_en, periph_en}, {2'b00, 16'h7fff});
      if (src == 0) irq_req <= 1'b1;
      else evt <= (src == 1) ? 6'h20 : 6'h08;
      do @(posedge pclk); while (irq_pending !== 1'b1 && evt == 6'h0);
      evt <= 6'h0;
    end
    n = 0;
    while (cpu_run !== 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    // Count includes the sampling edge after resume
    if (coinc) chk("late wake", n < 12, 1'b1);
    else chk("wake delay", n >= 3 && n <= 5, 1'b1);
    irq_req <= 1'b0;
    rchk("idle flag", `PSRS_OFF_RCAUSE, (src == 2) ? 32'h84 : 32'h04);
    $display("test idle %0d done", src);
  endtask
  task automatic t_doze();
    int n;
    for (int r = 0; r < 9; r++) begin
      apb(1'b1, `PSRS_OFF_CLOCK_DIVIDER_REGISTER, (r == 8) ? 32'h7000 : (32'h0800 | (r << 12)));
      repeat (2) @(posedge pclk);
      n = 0;
      repeat (256) begin
        @(posedge pclk);
        if (cpu_clk_en === 1'b1) n++;
      end
      chk("ticks", n, (r == 8) ? 256 : (256 >> r));
    end
    apb(1'b1, `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'hb800);
    irq_req <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk("roi", `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'hb000);
    // Drop the return bit first; while it is set the pending interrupt beats the doze write
    apb(1'b1, `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h3000);
    apb(1'b1, `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h3800);
    repeat (4) @(posedge pclk);
    rchk("no roi", `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h3800);
    irq_req <= 1'b0;
    apb(1'b1, `PSRS_OFF_CLOCK_DIVIDER_REGISTER, 32'h0);
    $display("test doze done");
  endtask
  task automatic t_moddis();
    apb(1'b1, `PSRS_OFF_MODDIS, 32'h8005);
    @(posedge pclk);
    chk("pe hold", periph_en, 16'h7fff);
    @(posedge pclk);
    chk("pe off", periph_en, 16'h7ffa);
    apb(1'b1, `PSRS_OFF_MODDIS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("pe on", periph_en, 16'h7fff);
    do_reset();
    rchk("por again", `PSRS_OFF_RCAUSE, 32'h3);
    $display("test moddis done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    evt = 6'h0;
    go = 1'b0;
    irq_req = 1'b0;
    watchdog_fuse_enable = 1'b0;
    fail_safe_clock_monitor = 1'b0;
    do_reset();
    t_reset();
    t_cause();
    t_idle(0, 1'b0);
    t_idle(1, 1'b0);
    t_idle(2, 1'b0);
    t_idle(0, 1'b1);
    t_doze();
    t_moddis();
    end_of_test();
  end
  // Run needs about 2600 cycles
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule
